// File: design/osdfx_linerep.sv
`timescale 1ns/1ns
module osdfx_linerep (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Scan timing
   input wire logic i_row_start,
   input wire logic i_line_end,
   // Settings
   input wire logic i_enable,
   input wire logic [7:0] i_row_lines,
   // Result
   output logic [4:0] o_char_line,
   output logic o_row_done
);
   import osdfx_pkg::*;

   typedef struct packed {
      logic [4:0] line;
      logic [7:0] acc;
      logic done;
   } osdfx_rep_state_t;

   localparam logic [8:0] STEP = 9'(CELL_LINES);

   osdfx_rep_state_t s_q;
   osdfx_rep_state_t s_d;
   logic [8:0] span;
   logic [8:0] acc_n;

   always_comb begin
      // Spans below the cell height would shrink characters
      span = (!i_enable || i_row_lines < 8'(CELL_LINES)) ? STEP : {1'b0, i_row_lines}; // see (RL19)
      acc_n = {1'b0, s_q.acc} + STEP;
      s_d = s_q;
      s_d.done = 1'b0;
      if (i_row_start) begin
         s_d.line = 5'h0000;
         s_d.acc = 8'h0000;
      end else if (i_line_end) begin
         // Error accumulator spreads the repeats over the row
         if (acc_n >= span) begin // see (RL18)
            s_d.acc = 8'(acc_n - span);
            if (s_q.line == LAST_LINE) begin
               s_d.done = 1'b1;
            end else begin
               s_d.line = s_q.line + 5'h0001;
            end
         end else begin
            s_d.acc = acc_n[7:0];
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         s_q <= '0;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_char_line = s_q.line;
   assign o_row_done = s_q.done;

endmodule

// File: design/osdfx_pkg.sv
// How it works
// (RL1) Top feature-select bit set means box edges are drawn around the character.
// (RL2) Depressed bit picks raised or depressed; heavy bit picks normal or heavy box.
// (RL3) Normal box lowlight uses normal lowlight colour; heavy box uses heavy shadow colour.
// (RL4) Box pixels are replaced by the highlight colour or the applicable lowlight colour.
// (RL5) Own box may only overwrite the cell's top line and rightmost column.
// (RL6) Left edge is drawn in the rightmost column of the preceding character.
// (RL7) Bottom edge goes on top line below, or on the first skip line.
// (RL8) Software never boxes a window's leftmost character; uses a blank first character.
// (RL9) Software adds a skip line below a bottom row that holds boxes.
// (RL10) Software puts no skip lines inside a multi-row box.
// (RL11) Shadow uses the current font line and the line directly above it.
// (RL12) Current bit X is compared with bit X+1 of the line above.
// (RL13) Bit 11 of the current line is never shadowed.
// (RL14) Shadow mask bit 1 recolours the pixel with the heavy shadow colour.
// (RL15) Border uses the current font line plus the lines above and below.
// (RL16) Border mask from all eight neighbours; mask bit 1 gives heavy shadow colour.
// (RL17) Border results on cell perimeter lines and columns are not guaranteed.
// (RL18) Character lines are repeated so character height tracks image height.
// (RL19) Repetition only adds lines; a character never shows fewer than 18 lines.
// (RL20) Software keeps the two display windows from overlapping.
// (RL21) Software leaves at least two characters horizontally between the windows.
// (RL22) Codes 1xxx are boxes: bit 2 heavy, bit 1 depressed, bit 0 blinking.
// (RL23) Shadow bit is 1 when up-left pixel is lit and current pixel unlit.
// (RL24) Border bit is 1 when pixel unlit and any of eight neighbours lit.
// (RL25) Shadow and border act only for their own feature codes; else pass through.
package osdfx_pkg;

   // ==========================================================
   // Character cell geometry
   localparam int unsigned CELL_COLS = 12;
   localparam int unsigned CELL_LINES = 18;
   localparam logic [4:0] LAST_LINE = 5'h0011;
   localparam logic [3:0] LAST_COL = 4'h000b;

   // ==========================================================
   // Feature-select field
   localparam int unsigned FSEL_W = 4;
   localparam int unsigned BOX_ENABLE_BIT = 3;
   localparam int unsigned BOX_HEAVY_BIT = 2;
   localparam int unsigned BOX_DEPRESSED_BIT = 1;
   localparam int unsigned BLINK_BIT = 0;
   localparam logic [3:0] FSEL_NONE = 4'h0000;
   localparam logic [3:0] FSEL_BLINK = 4'h0001;
   localparam logic [3:0] FSEL_SHADOW = 4'h0002;
   localparam logic [3:0] FSEL_BORDER = 4'h0003;

   // ==========================================================
   // Register map (byte offsets)
   localparam logic [7:0] OFS_CTRL = 8'h0000;
   localparam logic [7:0] OFS_BOX_HIGHLIGHT = 8'h0004;
   localparam logic [7:0] OFS_NORMAL_LOWLIGHT = 8'h0008;
   localparam logic [7:0] OFS_HEAVY_SHADOW = 8'h000c;
   localparam logic [7:0] OFS_ROW_LINES = 8'h0010;
   localparam logic [7:0] OFS_STATUS = 8'h0014;

   // Control fields
   localparam int unsigned CTRL_FX_EN = 0;
   localparam int unsigned CTRL_REP_EN = 1;

   // Status fields
   localparam int unsigned STAT_LINE_LSB = 0;
   localparam int unsigned STAT_CNT_LSB = 16;

   // ==========================================================
   // Reset values
   localparam logic RST_FX_EN = 1'b1;
   localparam logic RST_REP_EN = 1'b0;
   localparam logic [7:0] RST_ROW_LINES = 8'h0012;
   localparam logic [8:0] RST_BOX_HIGHLIGHT = 9'h01ff;
   localparam logic [8:0] RST_NORMAL_LOWLIGHT = 9'h0092;
   localparam logic [8:0] RST_HEAVY_SHADOW = 9'h0000;

   // ==========================================================
   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

endpackage

// File: design/osdfx_top.sv
`timescale 1ns/1ns
module osdfx_top #(
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned COLOR_W = 9
) (
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ce,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [ADDR_W-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // Scan line timing
   input wire logic i_row_start,
   input wire logic i_line_end,
   input wire logic i_skip_line,
   input wire logic i_first_skip,
   output logic [4:0] o_char_line,
   output logic o_row_done,
   // Pixel stream in
   input wire logic i_pix_valid,
   input wire logic [3:0] i_pix_col,
   input wire logic [COLOR_W-1:0] i_pix_color,
   input wire logic [osdfx_pkg::FSEL_W-1:0] i_feature_select_field,
   input wire logic [osdfx_pkg::FSEL_W-1:0] i_next_feature,
   input wire logic [osdfx_pkg::FSEL_W-1:0] i_above_feature,
   input wire logic [osdfx_pkg::CELL_COLS-1:0] i_font_cur,
   input wire logic [osdfx_pkg::CELL_COLS-1:0] i_font_above,
   input wire logic [osdfx_pkg::CELL_COLS-1:0] i_font_below,
   // Pixel stream out
   output logic o_pix_valid,
   output logic [COLOR_W-1:0] o_pix_color,
   output logic o_pix_blink,
   output logic o_pix_override
);
   import osdfx_pkg::*;

   // ==========================================================
   // Parameter checks
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 5 and 32");
   end
   if (COLOR_W < 1 || COLOR_W > 15) begin : g_bad_color
      $error("COLOR_W must lie between 1 and 15");
   end

   localparam int unsigned CW = CELL_COLS;

   typedef struct packed {
      logic wr_pend;
      logic [ADDR_W-1:0] wr_addr;
      logic [31:0] rdata;
      logic fx_en;
      logic rep_en;
      logic [COLOR_W-1:0] c_high;
      logic [COLOR_W-1:0] c_low;
      logic [COLOR_W-1:0] c_heavy;
      logic [7:0] row_lines;
      logic [15:0] ovr_cnt;
      logic pix_valid;
      logic [COLOR_W-1:0] pix_color;
      logic pix_blink;
      logic pix_ovr;
   } osdfx_top_state_t;

   osdfx_top_state_t s_q;
   osdfx_top_state_t s_d;

   // ==========================================================
   // Mask functions; bit 11 is the leftmost pixel
   function automatic logic [CW-1:0] shadow_mask(input logic [CW-1:0] cur,
                                                 input logic [CW-1:0] above);
      logic [CW-1:0] m;
      m = '0;
      // Pixel above-left lit, own pixel dark
      m[CW-2:0] = above[CW-1:1] & ~cur[CW-2:0]; // see (RL12) (RL23)
      m[CW-1] = 1'b0; // see (RL13)
      return m;
   endfunction

   function automatic logic [CW-1:0] spread(input logic [CW-1:0] v);
      return v | (v << 1) | (v >> 1);
   endfunction

   function automatic logic [CW-1:0] border_mask(input logic [CW-1:0] cur,
                                                 input logic [CW-1:0] above,
                                                 input logic [CW-1:0] below);
      logic [CW-1:0] near;
      // Edges see zero outside the cell, so perimeter may be wrong
      near = spread(above) | spread(below) | (cur << 1) | (cur >> 1); // see (RL16) (RL17)
      return near & ~cur; // see (RL24)
   endfunction

   function automatic logic is_box(input logic [FSEL_W-1:0] f);
      return f[BOX_ENABLE_BIT]; // see (RL1) (RL22)
   endfunction

   function automatic logic [COLOR_W-1:0] reg_color(input logic [31:0] w);
      return w[COLOR_W-1:0];
   endfunction

   // ==========================================================
   // Line repetition
   logic [4:0] char_line;
   logic row_done;

   osdfx_linerep u_linerep (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_row_start(i_row_start),
      .i_line_end(i_line_end),
      .i_enable(s_q.rep_en),
      .i_row_lines(s_q.row_lines),
      .o_char_line(char_line),
      .o_row_done(row_done)
   );

   // ==========================================================
   // Bus decode
   logic addr_phase;
   logic rd_req;
   logic wr_req;
   logic [7:0] rd_ofs;
   logic [7:0] wr_ofs;
   logic [31:0] rd_word;
   logic [31:0] status_word;

   always_comb begin
      addr_phase = i_hsel && i_hready && i_ce &&
                   (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);
      rd_req = addr_phase && !i_hwrite;
      wr_req = addr_phase && i_hwrite;
      rd_ofs = 8'(i_haddr);
      wr_ofs = 8'(s_q.wr_addr);
   end

   always_comb begin
      status_word = '0;
      status_word[STAT_LINE_LSB +: 5] = char_line;
      status_word[STAT_CNT_LSB +: 16] = s_q.ovr_cnt;
      rd_word = '0;
      unique case (rd_ofs)
         OFS_CTRL: begin
            rd_word[CTRL_FX_EN] = s_q.fx_en;
            rd_word[CTRL_REP_EN] = s_q.rep_en;
         end
         OFS_BOX_HIGHLIGHT: rd_word[COLOR_W-1:0] = s_q.c_high;
         OFS_NORMAL_LOWLIGHT: rd_word[COLOR_W-1:0] = s_q.c_low;
         OFS_HEAVY_SHADOW: rd_word[COLOR_W-1:0] = s_q.c_heavy;
         OFS_ROW_LINES: rd_word[7:0] = s_q.row_lines;
         OFS_STATUS: rd_word = status_word;
         default: rd_word = '0;
      endcase
      // Read straight after a write to the same word sees the new data, except the status word, which still shows the old count
      // Unmapped words stay zero even straight after a write
      if (s_q.wr_pend && wr_ofs == rd_ofs &&
          (rd_ofs == OFS_CTRL || rd_ofs == OFS_BOX_HIGHLIGHT || rd_ofs == OFS_NORMAL_LOWLIGHT ||
           rd_ofs == OFS_HEAVY_SHADOW || rd_ofs == OFS_ROW_LINES)) begin
         rd_word = i_hwdata & (rd_ofs == OFS_ROW_LINES ? 32'h0000_00ff :
                               rd_ofs == OFS_CTRL ? 32'h0000_0003 :
                               32'((1 << COLOR_W) - 1));
      end
   end

   // ==========================================================
   // Pixel override
   logic [3:0] bit_idx;
   logic [CW-1:0] sh_m;
   logic [CW-1:0] bd_m;
   logic top_line;
   logic own_top;
   logic own_right;
   logic left_edge;
   logic bottom_edge;
   logic [COLOR_W-1:0] own_low;
   logic [COLOR_W-1:0] next_low;
   logic [COLOR_W-1:0] above_low;
   logic [COLOR_W-1:0] pix_out;
   logic pix_ovr;

   always_comb begin
      bit_idx = LAST_COL - i_pix_col;
      sh_m = shadow_mask(i_font_cur, i_font_above); // see (RL11)
      bd_m = border_mask(i_font_cur, i_font_above, i_font_below); // see (RL15)
      top_line = !i_skip_line && char_line == 5'h0000;
      // Own box reaches only its top line and right column
      own_top = is_box(i_feature_select_field) && top_line; // see (RL5)
      own_right = is_box(i_feature_select_field) && !i_skip_line &&
                  i_pix_col == LAST_COL; // see (RL5)
      left_edge = is_box(i_next_feature) && !i_skip_line && i_pix_col == LAST_COL; // see (RL6)
      bottom_edge = is_box(i_above_feature) && (i_skip_line ? i_first_skip : top_line); // see (RL7)
      own_low = i_feature_select_field[BOX_HEAVY_BIT] ? s_q.c_heavy : s_q.c_low; // see (RL3)
      next_low = i_next_feature[BOX_HEAVY_BIT] ? s_q.c_heavy : s_q.c_low; // see (RL3)
      above_low = i_above_feature[BOX_HEAVY_BIT] ? s_q.c_heavy : s_q.c_low; // see (RL3)
      pix_out = i_pix_color;
      pix_ovr = 1'b1;
      // Raised: top and left lit, right and bottom dark; depressed swaps
      if (!s_q.fx_en) begin
         pix_ovr = 1'b0;
      end else if (own_top) begin
         pix_out = i_feature_select_field[BOX_DEPRESSED_BIT] ? own_low : s_q.c_high; // see (RL2) (RL4)
      end else if (own_right) begin
         pix_out = i_feature_select_field[BOX_DEPRESSED_BIT] ? s_q.c_high : own_low; // see (RL2) (RL4)
      end else if (left_edge) begin
         pix_out = i_next_feature[BOX_DEPRESSED_BIT] ? next_low : s_q.c_high; // see (RL6) (RL4)
      end else if (bottom_edge) begin
         pix_out = i_above_feature[BOX_DEPRESSED_BIT] ? s_q.c_high : above_low; // see (RL7) (RL4)
      end else if (!i_skip_line && i_feature_select_field == FSEL_SHADOW &&
                   sh_m[bit_idx]) begin // see (RL25)
         pix_out = s_q.c_heavy; // see (RL14)
      end else if (!i_skip_line && i_feature_select_field == FSEL_BORDER &&
                   bd_m[bit_idx]) begin // see (RL25)
         pix_out = s_q.c_heavy; // see (RL16)
      end else begin
         pix_ovr = 1'b0;
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.wr_pend = wr_req;
      if (wr_req) begin
         s_d.wr_addr = i_haddr;
      end
      if (rd_req) begin
         s_d.rdata = rd_word;
      end
      if (s_q.wr_pend) begin
         unique case (wr_ofs)
            OFS_CTRL: begin
               s_d.fx_en = i_hwdata[CTRL_FX_EN];
               s_d.rep_en = i_hwdata[CTRL_REP_EN];
            end
            OFS_BOX_HIGHLIGHT: s_d.c_high = reg_color(i_hwdata);
            OFS_NORMAL_LOWLIGHT: s_d.c_low = reg_color(i_hwdata);
            OFS_HEAVY_SHADOW: s_d.c_heavy = reg_color(i_hwdata);
            OFS_ROW_LINES: s_d.row_lines = i_hwdata[7:0];
            OFS_STATUS: s_d.ovr_cnt = '0;
            default: s_d.wr_pend = wr_req;
         endcase
      end
      // Count wins over a clear in the same cycle; saturates
      if (i_pix_valid && pix_ovr && s_d.ovr_cnt != 16'hffff) begin
         s_d.ovr_cnt = s_d.ovr_cnt + 16'h0001;
      end
      s_d.pix_valid = i_pix_valid;
      if (i_pix_valid) begin
         s_d.pix_color = pix_out;
         s_d.pix_ovr = pix_ovr;
         s_d.pix_blink = i_feature_select_field[BLINK_BIT] &&
                         (is_box(i_feature_select_field) ||
                          i_feature_select_field == FSEL_BLINK); // see (RL22)
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         s_q <= '0;
         s_q.fx_en <= RST_FX_EN;
         s_q.rep_en <= RST_REP_EN;
         s_q.c_high <= COLOR_W'(RST_BOX_HIGHLIGHT);
         s_q.c_low <= COLOR_W'(RST_NORMAL_LOWLIGHT);
         s_q.c_heavy <= COLOR_W'(RST_HEAVY_SHADOW);
         s_q.row_lines <= RST_ROW_LINES;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs; bus stalls while the clock enable is low
   assign o_hreadyout = i_ce;
   assign o_hresp = 1'b0;
   assign o_hrdata = s_q.rdata;
   assign o_char_line = char_line;
   assign o_row_done = row_done;
   assign o_pix_valid = s_q.pix_valid;
   assign o_pix_color = s_q.pix_color;
   assign o_pix_blink = s_q.pix_blink;
   assign o_pix_override = s_q.pix_ovr;

endmodule

// File: verif/osdfx_font_model.sv
`timescale 1ns/1ns
module osdfx_font_model (
   // Line select
   input wire logic [4:0] i_line,
   input wire logic i_skip,
   // Font lines
   output logic [11:0] o_cur,
   output logic [11:0] o_above,
   output logic [11:0] o_below
);
   function automatic logic [11:0] glyph(input logic [4:0] l);
      return 12'h0a5c ^ {3{l[3:0]}};
   endfunction
   // Skip lines carry no font; rows outside the cell read unlit
   always_comb begin
      o_cur = i_skip ? 12'h0000 : glyph(i_line);
      o_above = (i_skip || i_line == 5'h00) ? 12'h0000 : glyph(i_line - 5'h01);
      o_below = (i_skip || i_line == 5'h11) ? 12'h0000 : glyph(i_line + 5'h01);
   end
endmodule

// File: verif/osdfx_props.sv
`timescale 1ns/1ns
module osdfx_props #(
   parameter int unsigned COLOR_W = 9
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Watched inputs
   input wire logic i_row_start,
   input wire logic i_line_end,
   input wire logic i_skip_line,
   input wire logic i_pix_valid,
   input wire logic [3:0] i_pix_col,
   input wire logic [COLOR_W-1:0] i_pix_color,
   input wire logic [3:0] i_feature_select_field,
   input wire logic [3:0] i_next_feature,
   input wire logic [3:0] i_above_feature,
   // Watched outputs
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic o_pix_valid,
   input wire logic [COLOR_W-1:0] o_pix_color,
   input wire logic o_pix_blink,
   input wire logic [4:0] o_char_line,
   input wire logic o_row_done
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   logic plain;
   // No neighbour box can reach this pixel
   assign plain = i_ce && i_pix_valid && !i_next_feature[3] && !i_above_feature[3] && !i_skip_line;

   // ==========================================================
   // Pixel path
   property p_pass; plain && i_feature_select_field[3:1] == 3'h0 |=> o_pix_color == $past(i_pix_color); endproperty
   a_pass: assert property (p_pass) else $error("plain pixel altered");
   property p_bit11; plain && i_feature_select_field == 4'h2 && i_pix_col == 4'h0 |=> o_pix_color == $past(i_pix_color); endproperty
   a_bit11: assert property (p_bit11) else $error("leftmost pixel shadowed");
   property p_inside; plain && i_feature_select_field[3] && i_pix_col != 4'hb && o_char_line != 5'h00 |=> o_pix_color == $past(i_pix_color); endproperty
   a_inside: assert property (p_inside) else $error("box drew inside cell");
   property p_valid; i_ce |=> o_pix_valid == $past(i_pix_valid); endproperty
   a_valid: assert property (p_valid) else $error("pixel valid not one cycle later");
   property p_blink; i_ce && i_pix_valid |=> o_pix_blink == ($past(i_feature_select_field) == 4'h1 || ($past(i_feature_select_field[3]) && $past(i_feature_select_field[0]))); endproperty
   a_blink: assert property (p_blink) else $error("blink flag wrong");

   // ==========================================================
   // Line repetition
   property p_line_max; o_char_line <= 5'h11; endproperty
   a_line_max: assert property (p_line_max) else $error("char line beyond 17");
   property p_line_step; i_ce && i_line_end && !i_row_start |=> o_char_line == $past(o_char_line) || o_char_line == $past(o_char_line) + 5'h01; endproperty
   a_line_step: assert property (p_line_step) else $error("char line skipped");
   property p_done; i_ce && o_row_done |-> o_char_line == 5'h11 ##1 !o_row_done; endproperty
   a_done: assert property (p_done) else $error("row done misplaced");
   property p_start; i_ce && i_row_start && !i_line_end |=> o_char_line == 5'h00; endproperty
   a_start: assert property (p_start) else $error("row start did not clear line");
   property p_bus; o_hreadyout == i_ce && o_hresp == 1'b0; endproperty
   a_bus: assert property (p_bus) else $error("bus response wrong");
endmodule

bind osdfx_top osdfx_props #(.COLOR_W(COLOR_W)) u_props (.i_mclk(i_mclk), .i_reset(i_reset),
   .i_ce(i_ce), .i_row_start(i_row_start), .i_line_end(i_line_end), .i_skip_line(i_skip_line),
   .i_pix_valid(i_pix_valid), .i_pix_col(i_pix_col), .i_pix_color(i_pix_color),
   .i_feature_select_field(i_feature_select_field), .i_next_feature(i_next_feature),
   .i_above_feature(i_above_feature), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .o_pix_valid(o_pix_valid), .o_pix_color(o_pix_color), .o_pix_blink(o_pix_blink),
   .o_char_line(o_char_line), .o_row_done(o_row_done));

// File: verif/tb_osd_char_pixel_effects.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_osd_char_pixel_effects;
   import osdfx_pkg::*;
   localparam logic [8:0] HL = 9'h00f0;
   localparam logic [8:0] HV = 9'h0155;
   localparam logic [8:0] NL = 9'h0092;
   localparam logic [8:0] CI = 9'h00aa;
   logic mclk = 1'b0;
   logic ce = 1'b1;
   logic rst = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, rs = 1'b0, le = 1'b0, skip = 1'b0, first = 1'b0;
   logic pv = 1'b0, hready, hresp, row_done, opv, oblink, oovr;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
   logic [3:0] pcol = 4'h0, fsel = 4'h0, nxt = 4'h0, abv = 4'h0;
   logic [8:0] pcolor = 9'h0000, ocol;
   logic [4:0] char_line;
   logic [11:0] cur, abo, bel;
   int mismatches = 0;
   int n_checks = 0;
   always #20 mclk = ~mclk;

   osdfx_top dut (.i_mclk(mclk), .i_reset(rst), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_row_start(rs),
      .i_line_end(le), .i_skip_line(skip), .i_first_skip(first), .o_char_line(char_line),
      .o_row_done(row_done), .i_pix_valid(pv), .i_pix_col(pcol), .i_pix_color(pcolor),
      .i_feature_select_field(fsel), .i_next_feature(nxt), .i_above_feature(abv),
      .i_font_cur(cur), .i_font_above(abo), .i_font_below(bel), .o_pix_valid(opv),
      .o_pix_color(ocol), .o_pix_blink(oblink), .o_pix_override(oovr));
   osdfx_font_model u_font (.i_line(char_line), .i_skip(skip), .o_cur(cur), .o_above(abo),
      .o_below(bel));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge mclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 100) begin
            mismatches++;
            complete_run();
         end
         @(posedge mclk);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic pix(input logic [3:0] f, n, a, c, input logic [8:0] e, input logic eb,
      input string nm);
      @(posedge mclk);
      pv <= 1'b1;
      fsel <= f;
      nxt <= n;
      abv <= a;
      pcol <= c;
      pcolor <= CI;
      @(posedge mclk);
      pv <= 1'b0;
      @(negedge mclk);
      `CHK(nm, e, ocol)
      `CHK(nm, eb, oblink)
      `CHK(nm, 1'b1, opv)
      `CHK(nm, e != CI, oovr)
   endtask

   task automatic le_pulse();
      @(posedge mclk);
      le <= 1'b1;
      @(posedge mclk);
      le <= 1'b0;
   endtask

   task automatic goto_line(input int l);
      @(posedge mclk);
      rs <= 1'b1;
      @(posedge mclk);
      rs <= 1'b0;
      repeat (l) le_pulse();
      @(negedge mclk);
   endtask

   task automatic t_regs();
      logic [7:0] a[6] = '{OFS_CTRL, OFS_BOX_HIGHLIGHT, OFS_NORMAL_LOWLIGHT, OFS_HEAVY_SHADOW,
         OFS_ROW_LINES, 8'h18};
      logic [31:0] e[6] = '{32'h0000_0001, 32'h0000_01ff, 32'h0000_0092, 32'h0000_0000,
         32'h0000_0012, 32'h0000_0000};
      for (int i = 0; i < 6; i++) begin
         ahb(1'b0, a[i], 32'h0000_0000);
         `CHK("reset reg", e[i], rd)
      end
      ahb(1'b1, OFS_BOX_HIGHLIGHT, {23'h0, HL});
      ahb(1'b1, OFS_HEAVY_SHADOW, {23'h0, HV});
      ahb(1'b1, 8'h18, 32'hffff_ffff);
      ahb(1'b0, OFS_HEAVY_SHADOW, 32'h0000_0000);
      `CHK("shadow colour", {23'h0, HV}, rd)
      ahb(1'b0, 8'h18, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rd)
   endtask

   task automatic t_box();
      logic [3:0] f;
      logic [8:0] lo, top, side;
      for (int k = 8; k < 16; k++) begin
         f = 4'(k);
         lo = f[2] ? HV : NL;
         top = f[1] ? lo : HL;
         side = f[1] ? HL : lo;
         goto_line(0);
         pix(f, 4'h0, 4'h0, 4'h5, top, f[0], "box top");
         goto_line(1);
         pix(f, 4'h0, 4'h0, 4'hb, side, f[0], "box right");
         pix(f, 4'h0, 4'h0, 4'h5, CI, f[0], "box inside");
      end
   endtask

   task automatic t_edges();
      goto_line(1);
      // Boxed character always has a plain one before it
      pix(4'h0, 4'h8, 4'h0, 4'hb, HL, 1'b0, "left raised");
      pix(4'h0, 4'he, 4'h0, 4'hb, HV, 1'b0, "left heavy sunk");
      pix(4'h0, 4'h8, 4'h0, 4'ha, CI, 1'b0, "left off edge");
      goto_line(0);
      pix(4'h0, 4'h0, 4'h8, 4'h5, NL, 1'b0, "bottom raised");
      pix(4'h0, 4'h0, 4'ha, 4'h5, HL, 1'b0, "bottom sunk");
      @(posedge mclk);
      skip <= 1'b1;
      first <= 1'b1;
      pix(4'h0, 4'h0, 4'hc, 4'h5, HV, 1'b0, "skip bottom");
      first <= 1'b0;
      // Skip lines only below the box, never inside it
      pix(4'h0, 4'h0, 4'hc, 4'h5, CI, 1'b0, "later skip");
      skip <= 1'b0;
   endtask

   task automatic t_masks();
      logic [11:0] c, a, b;
      logic m;
      goto_line(5);
      c = cur;
      a = abo;
      b = bel;
      for (int x = 0; x < 12; x++) begin
         m = (x < 11) ? (a[x+1] & ~c[x]) : 1'b0;
         pix(FSEL_SHADOW, 4'h0, 4'h0, 4'(11 - x), m ? HV : CI, 1'b0, "shadow");
      end
      // Perimeter columns left out: not defined there
      for (int x = 1; x < 11; x++) begin
         m = ~c[x] & (a[x+1] | a[x] | a[x-1] | c[x+1] | c[x-1] | b[x+1] | b[x] | b[x-1]);
         pix(FSEL_BORDER, 4'h0, 4'h0, 4'(11 - x), m ? HV : CI, 1'b0, "border");
      end
      pix(FSEL_BLINK, 4'h0, 4'h0, 4'h9, CI, 1'b1, "blink only");
      pix(4'h5, 4'h0, 4'h0, 4'h9, CI, 1'b0, "reserved code");
      ahb(1'b1, OFS_CTRL, 32'h0000_0000);
      pix(FSEL_SHADOW, 4'h0, 4'h0, 4'h9, CI, 1'b0, "effects off");
      ahb(1'b1, OFS_CTRL, 32'h0000_0001);
      ahb(1'b1, OFS_STATUS, 32'h0000_0000);
      pix(FSEL_SHADOW, 4'h0, 4'h0, 4'h9, HV, 1'b0, "counted pixel");
      ahb(1'b0, OFS_STATUS, 32'h0000_0000);
      `CHK("status", 32'h0001_0005, rd)
   endtask

   task automatic t_rep();
      goto_line(17);
      `CHK("last line", 5'h11, char_line)
      le_pulse();
      @(negedge mclk);
      `CHK("row done", 1'b1, row_done)
      ahb(1'b1, OFS_ROW_LINES, 32'h0000_0024);
      ahb(1'b1, OFS_CTRL, 32'h0000_0003);
      goto_line(1);
      `CHK("repeated line", 5'h00, char_line)
      goto_line(2);
      `CHK("advanced line", 5'h01, char_line)
      ahb(1'b1, OFS_ROW_LINES, 32'h0000_000a);
      goto_line(3);
      `CHK("short span", 5'h03, char_line)
      // Enable low must freeze the line counter and stall the bus
      ce <= 1'b0;
      le_pulse();
      @(negedge mclk);
      `CHK("frozen line", 5'h03, char_line)
      `CHK("stalled bus", 1'b0, hready)
      ce <= 1'b1;
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_box();
      t_edges(); // One window only
      t_masks();
      t_rep();
      complete_run();
   end
endmodule
